// ==== echo_group_map.svh ====
`ifndef ECHO_GROUP_MAP_SVH
`define ECHO_GROUP_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GROUP1_MAIN_CONTROL_OFS 11'h401
`define GROUP2_MAIN_CONTROL_OFS 11'h402
`define GROUP3_MAIN_CONTROL_OFS 11'h403
`define IRQ_STATUS_OFS 11'h404
`define IRQ_MASK_OFS 11'h405

// ----------------------------------------------------------------
// Main control fields
// ----------------------------------------------------------------
`define MC_POWER_UP_BIT 0
`define MC_LAW_BIT 1
`define MC_FORMAT_BIT 2
`define MC_MASK_TONE_A_BIT 3
`define MC_MASK_TONE_B_BIT 4
`define MC_MASK_ALL_BIT 5
`define MC_WRITABLE 8'h3f
`define MC_RESET 8'h00

// ----------------------------------------------------------------
// Interrupt status layout: bits 2:0 tone event per group, 5:3 init done
// ----------------------------------------------------------------
`define IRQ_TONE_LSB 0
`define IRQ_INIT_LSB 3
`define IRQ_RESET 8'h00

// ----------------------------------------------------------------
// Initialization timing
// ----------------------------------------------------------------
`define INIT_FRAMES 2'h2
`define CHAN_REG_LAST 6'h3f

`endif

// ==== echo_group_pkg.sv ====
package echo_group_pkg;

    typedef enum logic [1:0]
    {
        GRP_IDLE = 2'h0,
        GRP_PRESET = 2'h1,
        GRP_WAIT = 2'h3
    } grp_state_t;

    typedef logic [7:0] pcm_t;

endpackage : echo_group_pkg

// ==== group_if.sv ====
`timescale 1ns/1ps

interface group_if;
    logic power_up;
    logic frame_tick;
    echo_group_pkg::pcm_t rin;
    echo_group_pkg::pcm_t sin;
    echo_group_pkg::pcm_t ec_rout;
    echo_group_pkg::pcm_t ec_sout;
    echo_group_pkg::pcm_t rout;
    echo_group_pkg::pcm_t sout;
    logic ec_active;
    logic preset_we;
    logic [5:0] preset_addr;
    logic coef_clear;
    logic init_busy;
    logic init_done;

    modport ctl
    (
        input power_up, frame_tick, rin, sin, ec_rout, ec_sout,
        output rout, sout, ec_active, preset_we, preset_addr, coef_clear, init_busy, init_done
    );
    modport top
    (
        output power_up, frame_tick, rin, sin, ec_rout, ec_sout,
        input rout, sout, ec_active, preset_we, preset_addr, coef_clear, init_busy, init_done
    );
endinterface : group_if

// ==== group_ctl.sv ====
`timescale 1ns/1ps
`include "echo_group_map.svh"

module group_ctl #(
    parameter int BYPASS_FRAMES = 1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    group_if.ctl g
);

    typedef struct packed {
        echo_group_pkg::grp_state_t state;
        logic pwr_d;
        logic [1:0] frames;
        logic [5:0] addr;
        logic done;
        logic [BYPASS_FRAMES-1:0][7:0] rin_dl;
        logic [BYPASS_FRAMES-1:0][7:0] sin_dl;
    } st_t;

    st_t r_r;
    st_t r_nxt;

    // ----------------------------------------------------------------
    // Power-up edge, preset walk and frame-counted init
    // ----------------------------------------------------------------
    always_comb
    begin
        r_nxt = r_r;
        r_nxt.pwr_d = g.power_up;
        r_nxt.done = 1'b0;
        if (g.frame_tick)
        begin
            // Bypass delay line advances once per frame.
            r_nxt.rin_dl = r_r.rin_dl >> 8; // [RULE3]
            r_nxt.sin_dl = r_r.sin_dl >> 8; // [RULE3]
            r_nxt.rin_dl[BYPASS_FRAMES-1] = g.rin;
            r_nxt.sin_dl[BYPASS_FRAMES-1] = g.sin;
        end
        unique case (r_r.state)
            echo_group_pkg::GRP_IDLE:
            begin
                if (g.power_up && !r_r.pwr_d) // [RULE4]
                begin
                    r_nxt.state = echo_group_pkg::GRP_PRESET;
                    r_nxt.addr = 6'h00;
                    r_nxt.frames = 2'h0;
                end
            end
            echo_group_pkg::GRP_PRESET:
            begin
                r_nxt.addr = r_r.addr + 6'h01; // [RULE5]
                if (r_r.addr == `CHAN_REG_LAST)
                begin
                    r_nxt.state = echo_group_pkg::GRP_WAIT;
                end
            end
            echo_group_pkg::GRP_WAIT:
            begin
                if (!g.power_up)
                begin
                    r_nxt.state = echo_group_pkg::GRP_IDLE;
                end
                else if (g.frame_tick)
                begin
                    r_nxt.frames = r_r.frames + 2'h1; // [RULE6]
                    if (r_r.frames + 2'h1 == `INIT_FRAMES)
                    begin
                        r_nxt.state = echo_group_pkg::GRP_IDLE;
                        r_nxt.done = 1'b1;
                    end
                end
            end
            default:
            begin
                r_nxt.state = echo_group_pkg::GRP_IDLE;
            end
        endcase
        if (g.frame_tick && r_r.state == echo_group_pkg::GRP_PRESET)
        begin
            r_nxt.frames = r_r.frames + 2'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign g.preset_we = (r_r.state == echo_group_pkg::GRP_PRESET); // [RULE5]
    assign g.preset_addr = r_r.addr;
    assign g.init_busy = (r_r.state != echo_group_pkg::GRP_IDLE); // [RULE6]
    assign g.coef_clear = g.init_busy; // [RULE7]
    assign g.init_done = r_r.done;
    assign g.ec_active = g.power_up; // [RULE2]
    assign g.rout = g.power_up ? g.ec_rout : r_r.rin_dl[0]; // [RULE3]
    assign g.sout = g.power_up ? g.ec_sout : r_r.sin_dl[0]; // [RULE3]

endmodule : group_ctl

// ==== echo_group_main_control.sv ====
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "echo_group_map.svh"

// Overview of operation
// RULE1: Group mask-all bit suppresses both tone interrupts; detectors keep running.
// RULE2: Power-up bit clear powers down both cancellers and detectors; set makes them active.
// RULE3: Powered-down group bypasses Rin to Rout and Sin to Sout, whole-frame delay.
// RULE4: Power-up bit rising starts the group initialization routine.
// RULE5: Initialization presets per-channel registers 00 through 3F to defaults.
// RULE6: Initialization lasts two frames; host writes channel registers afterwards.
// RULE7: Initialization clears all adaptive filter coefficients of both cancellers.
// RULE8: Format bit selects companded or sign-magnitude; law bit selects A or mu law.
module echo_group_main_control #(
    parameter int GROUPS = 3,
    parameter int BYPASS_FRAMES = 1
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [10:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic frame_sync,
    input wire logic [GROUPS-1:0] tone_a_det,
    input wire logic [GROUPS-1:0] tone_b_det,
    input wire logic [GROUPS-1:0][7:0] rin,
    input wire logic [GROUPS-1:0][7:0] sin,
    input wire logic [GROUPS-1:0][7:0] ec_rout,
    input wire logic [GROUPS-1:0][7:0] ec_sout,
    output logic [GROUPS-1:0][7:0] rout,
    output logic [GROUPS-1:0][7:0] sout,
    output logic [GROUPS-1:0] ec_power_up,
    output logic [GROUPS-1:0] ec_law,
    output logic [GROUPS-1:0] ec_format,
    output logic [GROUPS-1:0] tone_a_irq,
    output logic [GROUPS-1:0] tone_b_irq,
    output logic [GROUPS-1:0] preset_we,
    output logic [GROUPS-1:0][5:0] preset_addr,
    output logic [GROUPS-1:0] coef_clear,
    output logic [GROUPS-1:0] init_busy,
    output logic irq
);

    typedef struct packed {
        logic [GROUPS-1:0][7:0] ctrl;
        logic [7:0] status;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic [2:0] sync;
        logic frame_d;
    } st_t;

    st_t r_r;
    st_t r_nxt;
    logic [GROUPS-1:0] init_done;
    logic [GROUPS-1:0] tone_evt;
    logic frame_tick;

    function automatic int ctrl_index(input logic [10:0] a);
        ctrl_index = int'(a) - int'(`GROUP1_MAIN_CONTROL_OFS);
    endfunction : ctrl_index

    function automatic logic is_ctrl(input logic [10:0] a);
        is_ctrl = (a >= `GROUP1_MAIN_CONTROL_OFS) && (ctrl_index(a) < GROUPS);
    endfunction : is_ctrl

    // ----------------------------------------------------------------
    // Frame pulse synchroniser: a rise counts when stages two and three agree
    // ----------------------------------------------------------------
    assign frame_tick = (r_r.sync[1] == r_r.sync[2]) && r_r.sync[2] && !r_r.frame_d;

    // ----------------------------------------------------------------
    // Tone interrupt gating
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < GROUPS; i++)
        begin
            ec_power_up[i] = r_r.ctrl[i][`MC_POWER_UP_BIT]; // [RULE2]
            ec_law[i] = r_r.ctrl[i][`MC_LAW_BIT]; // [RULE8]
            ec_format[i] = r_r.ctrl[i][`MC_FORMAT_BIT]; // [RULE8]
            tone_a_irq[i] = tone_a_det[i] && r_r.ctrl[i][`MC_POWER_UP_BIT] && !r_r.ctrl[i][`MC_MASK_ALL_BIT]
                && !r_r.ctrl[i][`MC_MASK_TONE_A_BIT]; // [RULE1]
            tone_b_irq[i] = tone_b_det[i] && r_r.ctrl[i][`MC_POWER_UP_BIT] && !r_r.ctrl[i][`MC_MASK_ALL_BIT]
                && !r_r.ctrl[i][`MC_MASK_TONE_B_BIT]; // [RULE1]
            tone_evt[i] = tone_a_irq[i] || tone_b_irq[i];
        end
    end

    // ----------------------------------------------------------------
    // Register file and interrupt status
    // ----------------------------------------------------------------
    always_comb
    begin
        logic [7:0] set_bits;
        set_bits = 8'h00;
        r_nxt = r_r;
        r_nxt.sync = {r_r.sync[1:0], frame_sync};
        if (r_r.sync[1] == r_r.sync[2])
        begin
            r_nxt.frame_d = r_r.sync[2];
        end
        for (int i = 0; i < GROUPS; i++)
        begin
            set_bits[`IRQ_TONE_LSB + i] = tone_evt[i];
            set_bits[`IRQ_INIT_LSB + i] = init_done[i];
        end
        if (reg_wr && is_ctrl(reg_addr))
        begin
            r_nxt.ctrl[ctrl_index(reg_addr)] = reg_wdata & `MC_WRITABLE;
        end
        if (reg_wr && reg_addr == `IRQ_MASK_OFS)
        begin
            r_nxt.mask = reg_wdata;
        end
        if (reg_wr && reg_addr == `IRQ_STATUS_OFS)
        begin
            r_nxt.status = r_r.status & ~reg_wdata;
        end
        r_nxt.status = r_nxt.status | set_bits;
        r_nxt.rdata = 8'h00;
        if (reg_rd)
        begin
            if (is_ctrl(reg_addr))
            begin
                r_nxt.rdata = r_r.ctrl[ctrl_index(reg_addr)];
            end
            else if (reg_addr == `IRQ_STATUS_OFS)
            begin
                r_nxt.rdata = r_r.status;
            end
            else if (reg_addr == `IRQ_MASK_OFS)
            begin
                r_nxt.rdata = r_r.mask;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r_r <= '0;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    assign reg_rdata = r_r.rdata;
    assign irq = |(r_r.status & r_r.mask);

    // ----------------------------------------------------------------
    // Per-group control
    // ----------------------------------------------------------------
    for (genvar i = 0; i < GROUPS; i++)
    begin : grp
        group_if gi();
        assign gi.power_up = ec_power_up[i];
        assign gi.frame_tick = frame_tick;
        assign gi.rin = rin[i];
        assign gi.sin = sin[i];
        assign gi.ec_rout = ec_rout[i];
        assign gi.ec_sout = ec_sout[i];
        assign rout[i] = gi.rout;
        assign sout[i] = gi.sout;
        assign preset_we[i] = gi.preset_we;
        assign preset_addr[i] = gi.preset_addr;
        assign coef_clear[i] = gi.coef_clear;
        assign init_busy[i] = gi.init_busy;
        assign init_done[i] = gi.init_done;
        group_ctl #(
            .BYPASS_FRAMES(BYPASS_FRAMES)
        ) u_ctl (
            .clk(clk),
            .sys_rst(sys_rst),
            .g(gi.ctl)
        );
    end

endmodule : echo_group_main_control

// ==== echo_group_main_control_props.sv ====
`timescale 1ns/1ps
module echo_group_main_control_props #(
    parameter int GROUPS = 3
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [10:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [GROUPS-1:0] tone_a_det,
    input wire logic [GROUPS-1:0] tone_a_irq,
    input wire logic [GROUPS-1:0] ec_power_up,
    input wire logic [GROUPS-1:0] ec_law,
    input wire logic [GROUPS-1:0] ec_format,
    input wire logic [GROUPS-1:0][7:0] rout,
    input wire logic [GROUPS-1:0][7:0] ec_rout,
    input wire logic [GROUPS-1:0] preset_we,
    input wire logic [GROUPS-1:0][5:0] preset_addr,
    input wire logic [GROUPS-1:0] coef_clear,
    input wire logic [GROUPS-1:0] init_busy
);
    // ----------------------------------------
    // Group one watchers
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    property p_irq_cause;
        tone_a_irq[0] |-> tone_a_det[0] && ec_power_up[0];
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("tone irq without enabled event");
    property p_live;
        ec_power_up[0] |-> rout[0] == ec_rout[0];
    endproperty
    a_live: assert property (p_live) else $error("active group does not pass canceller output");
    property p_start;
        $rose(ec_power_up[0]) |=> init_busy[0] && preset_we[0] && preset_addr[0] == 6'h00;
    endproperty
    a_start: assert property (p_start) else $error("init did not start on power-up");
    property p_walk;
        preset_we[0] && preset_addr[0] != 6'h3f |=> preset_we[0] && preset_addr[0] == $past(preset_addr[0]) + 6'h01;
    endproperty
    a_walk: assert property (p_walk) else $error("preset walk broke");
    property p_walk_end;
        preset_we[0] && preset_addr[0] == 6'h3f |=> !preset_we[0];
    endproperty
    a_walk_end: assert property (p_walk_end) else $error("preset walk ran past the last register");
    property p_coef;
        preset_we[0] |-> coef_clear[0] && init_busy[0];
    endproperty
    a_coef: assert property (p_coef) else $error("coefficients not cleared during preset");
    property p_busy;
        $rose(init_busy[0]) |-> init_busy[0] [*8];
    endproperty
    a_busy: assert property (p_busy) else $error("init ended too early");
    property p_law;
        reg_wr && reg_addr == 11'h401 |=> ec_law[0] == $past(reg_wdata[1]) && ec_format[0] == $past(reg_wdata[2]);
    endproperty
    a_law: assert property (p_law) else $error("coding select does not follow the write");
    property p_law_other;
        reg_wr && reg_addr == 11'h402 |=> $stable(ec_law[0]) && $stable(ec_format[0]);
    endproperty
    a_law_other: assert property (p_law_other) else $error("coding select moved on another group write");
endmodule : echo_group_main_control_props

// ==== pcm_highway_model.sv ====
`timescale 1ns/1ps
module pcm_highway_model #(
    parameter int GROUPS = 3,
    parameter int FRAME = 100
)
(
    input wire logic clk,
    output logic frame_sync,
    output logic frame_last,
    output logic [GROUPS-1:0][7:0] rin,
    output logic [GROUPS-1:0][7:0] sin,
    output logic [GROUPS-1:0][7:0] ec_rout,
    output logic [GROUPS-1:0][7:0] ec_sout
);
    int cnt = 0;
    int frame = 1;
    initial rin = '0;
    assign frame_sync = cnt < 4;
    assign frame_last = cnt == FRAME - 1;
    assign sin = rin ^ {GROUPS{8'h5a}};
    assign ec_rout = ~rin;
    assign ec_sout = ~sin;
    // Samples change mid-frame, so a bypass without delay shows up at once.
    always @(posedge clk)
    begin
        cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
        if (cnt == FRAME / 2)
        begin
            frame <= frame + 1;
            for (int g = 0; g < GROUPS; g++)
            begin
                rin[g] <= 8'(frame * 37 + g * 11);
            end
        end
    end
endmodule : pcm_highway_model

// ==== tb_echo_group_main_control.sv ====
`timescale 1ns/1ps
module tb_echo_group_main_control;
    localparam int G = 3;
    localparam int BF = 2;
    localparam int FR = 100;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [10:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic frame_sync, frame_last, irq;
    logic [G-1:0] tone_a_det = '0;
    logic [G-1:0] tone_b_det = '0;
    logic [G-1:0] ec_power_up, ec_law, ec_format, tone_a_irq, tone_b_irq, preset_we, coef_clear, init_busy;
    logic [G-1:0][7:0] rin, sin, ec_rout, ec_sout, rout, sout;
    logic [G-1:0][5:0] preset_addr;
    int err_total = 0;
    int checks = 0;
    int ctl_m[G];
    logic [47:0] q[$];
    always #5 clk = ~clk;
    echo_group_main_control #(.BYPASS_FRAMES(BF)) echo_group_main_control_i (.*);
    pcm_highway_model #(.FRAME(FR)) pcm_highway_model_i (.*);
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic results();
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    task automatic wr(logic [10:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
        if (a >= 11'h401 && a <= 11'h403)
        begin
            ctl_m[int'(a - 11'h401)] = d & 8'h3f;
        end
    endtask : wr
    task automatic rd(logic [10:0] a, logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask : rd
    task automatic frames(logic [G-1:0] on);
        logic [47:0] e;
        q.delete();
        for (int f = 0; f < BF + 4; f++)
        begin
            for (int n = 0; n < 2 * FR && frame_last !== 1'b1; n++)
            begin
                @(posedge clk);
                #1;
            end
            if (frame_last !== 1'b1)
            begin
                err_total++;
                results();
            end
            e = (q.size() >= BF) ? q[q.size() - BF] : '0;
            for (int g = 0; g < G; g++)
            begin
                if (on[g])
                begin
                    e[8*g+:8] = ~rin[g];
                    e[24+8*g+:8] = ~sin[g];
                end
            end
            if (q.size() >= BF)
            begin
                chk("sout_rout", {sout, rout}, e);
            end
            q.push_back({sin, rin});
            @(posedge clk);
            #1;
        end
    endtask : frames
    task automatic tone(logic [G-1:0] exp);
        @(posedge clk);
        tone_a_det <= '1;
        tone_b_det <= '1;
        #1;
        chk("tone_irq", {tone_b_irq, tone_a_irq}, {exp, exp});
        @(posedge clk);
        tone_a_det <= '0;
        tone_b_det <= '0;
        @(posedge clk);
        #1;
        chk("irq", irq, |exp);
        rd(11'h404, {5'h00, exp});
        wr(11'h404, 8'h07);
    endtask : tone
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] d;
        int pw, cl, bs;
        void'($urandom(32'ha18a89c9));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 1; a < 7; a++)
        begin
            rd(11'h400 + 11'(a), 8'h00);
        end
        frames(3'b000);
        for (int g = 0; g < G; g++)
        begin
            d = 8'($urandom) & 8'hfe;
            wr(11'h401 + 11'(g), d);
            rd(11'h401 + 11'(g), 8'(ctl_m[g]));
            chk("law_fmt", {ec_format[g], ec_law[g]}, d[2:1]);
        end
        wr(11'h401, 8'(ctl_m[0] & 8'h07 | 1));
        pw = 0;
        cl = 0;
        bs = 0;
        for (int n = 0; n < 1000; n++)
        begin
            @(posedge clk);
            #1;
            pw += int'(preset_we[0] === 1'b1);
            cl += int'(coef_clear[0] === 1'b1);
            if (init_busy[0] !== 1'b1)
            begin
                break;
            end
            bs++;
        end
        chk("preset_count", pw, 64);
        chk("coef_count", cl, bs);
        chk("busy_span", bs >= FR && bs <= 2 * FR + 8, 1);
        chk("power_up", ec_power_up, 3'b001);
        wr(11'h405, 8'h09);
        rd(11'h404, 8'h08);
        chk("irq", irq, 1'b1);
        wr(11'h404, 8'h08);
        rd(11'h404, 8'h00);
        chk("irq", irq, 1'b0);
        frames(3'b001);
        tone(3'b001);
        wr(11'h401, 8'(ctl_m[0] | 8'h20));
        tone(3'b000);
        results();
    end
endmodule : tb_echo_group_main_control
bind echo_group_main_control echo_group_main_control_props #(.GROUPS(GROUPS)) props_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .tone_a_det(tone_a_det),
    .tone_a_irq(tone_a_irq),
    .ec_power_up(ec_power_up),
    .ec_law(ec_law),
    .ec_format(ec_format),
    .rout(rout),
    .ec_rout(ec_rout),
    .preset_we(preset_we),
    .preset_addr(preset_addr),
    .coef_clear(coef_clear),
    .init_busy(init_busy)
);
